//--- sws_consts.svh
`ifndef SWS_CONSTS_SVH
`define SWS_CONSTS_SVH

`define SWS_LANES          4
`define SWS_SYM_PER_WORD   7
`define SWS_WS_BITS        3
`define SWS_LANE_BITS      21
`define SWS_NUM_BITS       16
`define SWS_FLAG_POS       16
`define SWS_FIFO_DEPTH     16

`define SWS_CLK_MHZ        10
`define SWS_SYM_RATE_MSPS  35
`define SWS_MAX_RATE_MSPS  1400
`define SWS_HALF_CYC       ((`SWS_CLK_MHZ * `SWS_SYM_PER_WORD) / (2 * `SWS_SYM_RATE_MSPS))

`define SWS_LP_MIN_NS      50
`define SWS_LP_MIN_RAW     ((`SWS_LP_MIN_NS * `SWS_CLK_MHZ + 999) / 1000)
`define SWS_LP_MIN_CYC     ((`SWS_LP_MIN_RAW < 1) ? 1 : `SWS_LP_MIN_RAW)
`define SWS_NOISE_PRE_NS   30
`define SWS_NOISE_POST_NS  50

`define SWS_LP_STOP        3'h7
`define SWS_LP_HS_PREP     3'h0

`endif

//--- sws_pkg.sv
package sws_pkg;
    typedef struct packed {
        logic [20:0] ws;
        logic [15:0] num;
        logic        payload;
    } sws_lane_t;

    typedef sws_lane_t [3:0] sws_word_t;

    typedef enum logic [1:0] {
        SWS_LS_BLANK  = 2'b01,
        SWS_LS_STREAM = 2'b10
    } sws_lane_state_t;
endpackage

//--- sws_fifo_if.sv
interface sws_fifo_if #(
    parameter int WIDTH = 8
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport fifo (
        input  wr_valid,
        output wr_ready,
        input  wr_data,
        output rd_valid,
        input  rd_ready,
        output rd_data
    );

    modport user (
        output wr_valid,
        input  wr_ready,
        output wr_data,
        input  rd_valid,
        output rd_ready,
        input  rd_data
    );
endinterface

//--- sws_fifo.sv
module sws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic srst,
    sws_fifo_if.fifo  port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign port.wr_ready = (count != (AW+1)'(DEPTH));
    assign port.rd_valid = (count != '0);
    assign port.rd_data  = mem[rd_ptr];
    assign do_wr         = port.wr_valid && port.wr_ready;
    assign do_rd         = port.rd_valid && port.rd_ready;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= port.wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count <= '0;
        end else if (do_wr && !do_rd) begin
            count <= count + 1'b1;
        end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
        end
    end
endmodule

//--- sws_stream_out.sv
`include "sws_consts.svh"

module sws_stream_out (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              mode_data,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire sws_pkg::sws_word_t in_word,
    input  wire logic [3:0]        lp_a_pin,
    input  wire logic [3:0]        lp_b_pin,
    input  wire logic [3:0]        lp_c_pin,
    output logic                   stream_clk,
    output logic [3:0]             lp_a_out,
    output logic [3:0]             lp_b_out,
    output logic [3:0]             lp_c_out,
    output logic [83:0]            lane_bits
);
    localparam int MAX_RATE   = `SWS_MAX_RATE_MSPS;
    // past the guaranteed lane rate the divider is pinned to the cap
    localparam int SYM_RATE   = (`SWS_SYM_RATE_MSPS > MAX_RATE) ? MAX_RATE : `SWS_SYM_RATE_MSPS;
    localparam int HALF_RAW   = (`SWS_CLK_MHZ * `SWS_SYM_PER_WORD) / (2 * SYM_RATE);
    localparam int HALF_CYC   = (HALF_RAW < 1) ? 1 : HALF_RAW;
    localparam int LP_MIN_CYC = `SWS_LP_MIN_CYC;
    localparam int NOISE_PRE  = `SWS_NOISE_PRE_NS;
    localparam int NOISE_POST = `SWS_NOISE_POST_NS;

    // noise windows are neither detected nor masked: the receiver drops them
    // the two spans are kept for reference only, nothing here measures them

    // sixteen words absorb decoder bursts while the port drains one per period
    sws_fifo_if #(.WIDTH($bits(sws_pkg::sws_word_t))) fq ();

    sws_fifo #(
        .WIDTH ($bits(sws_pkg::sws_word_t)),
        .DEPTH (`SWS_FIFO_DEPTH)
    ) u_fifo (
        .clk  (clk),
        .srst (srst),
        .port (fq.fifo)
    );

    // back-pressure reaches the upstream decoder through in_ready
    assign fq.wr_valid = in_valid;
    assign fq.wr_data  = in_word;
    assign in_ready    = fq.wr_ready;

    // the buffer carries a flat vector; view it per lane again
    sws_pkg::sws_word_t rd_word;

    assign rd_word = fq.rd_data;

    // stream clock divider; a half period of one runs it at half the core clock
    logic [7:0] div_cnt;
    logic       fall_tick;

    assign fall_tick = (div_cnt == 8'(HALF_CYC - 1)) && stream_clk;

    always_ff @(posedge clk) begin
        if (srst) begin
            div_cnt <= 8'h00;
        end else if (div_cnt == 8'(HALF_CYC - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // one stream clock per seven symbols; rate capped for I/O bandwidth
    always_ff @(posedge clk) begin
        if (srst) begin
            stream_clk <= 1'b0;
        end else if (div_cnt == 8'(HALF_CYC - 1)) begin
            stream_clk <= ~stream_clk;
        end
    end

    // words drain on the falling edge so they stand still at the rising one
    assign fq.rd_ready = fall_tick;

    // low-power level capture, three stages per pin
    logic [3:0][2:0] lp_s1;
    logic [3:0][2:0] lp_s2;
    logic [3:0][2:0] lp_s3;
    logic [3:0][2:0] lp_lvl;
    logic [3:0]      lane_blank;

    function automatic logic sws_lp_is(
        input logic [2:0] code,
        input logic [2:0] want
    );
        sws_lp_is = (code == want);
    endfunction

    // data mode pads the top four bits of each lane with zeros
    function automatic logic [20:0] sws_lane_pick(
        input sws_pkg::sws_lane_t lane,
        input logic               data_mode
    );
        if (data_mode) begin
            sws_lane_pick = {4'h0, lane.payload, lane.num};
        end else begin
            sws_lane_pick = lane.ws;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [3:0]               stab_cnt;
            logic [20:0]              next_lane;
            logic [2:0]               lp_qual;
            sws_pkg::sws_lane_state_t lstate;

            always_ff @(posedge clk) begin
                if (srst) begin
                    lp_s1[g] <= 3'h7;
                    lp_s2[g] <= 3'h7;
                    lp_s3[g] <= 3'h7;
                end else begin
                    lp_s1[g] <= {lp_a_pin[g], lp_b_pin[g], lp_c_pin[g]};
                    lp_s2[g] <= lp_s1[g];
                    lp_s3[g] <= lp_s2[g];
                end
            end

            // a pin change counts only once stages two and three agree
            always_ff @(posedge clk) begin
                if (srst) begin
                    lp_lvl[g] <= 3'h7;
                end else if (lp_s2[g] == lp_s3[g]) begin
                    lp_lvl[g] <= lp_s3[g];
                end
            end

            // a state must hold its minimum period before it counts
            // shorter glitches never reach lp_qual, so they cannot blank a lane
            always_ff @(posedge clk) begin
                if (srst) begin
                    stab_cnt <= 4'h0;
                    lp_qual  <= 3'h7;
                end else if (lp_s2[g] != lp_s3[g] || lp_s3[g] != lp_lvl[g]) begin
                    stab_cnt <= 4'h0;
                end else if (stab_cnt < 4'(LP_MIN_CYC)) begin
                    stab_cnt <= stab_cnt + 4'h1;
                end else begin
                    lp_qual <= lp_lvl[g];
                end
            end

            // lanes wake blanked so nothing streams before an entry sequence
            always_ff @(posedge clk) begin
                if (srst) begin
                    lstate <= sws_pkg::SWS_LS_BLANK;
                end else begin
                    case (lstate)
                        sws_pkg::SWS_LS_STREAM: begin
                            if (sws_lp_is(lp_qual, `SWS_LP_STOP)) begin
                                lstate <= sws_pkg::SWS_LS_BLANK;
                            end
                        end
                        sws_pkg::SWS_LS_BLANK: begin
                            if (sws_lp_is(lp_qual, `SWS_LP_HS_PREP)) begin
                                lstate <= sws_pkg::SWS_LS_STREAM;
                            end
                        end
                        // a corrupted one-hot code falls back to blanking
                        default: begin
                            lstate <= sws_pkg::SWS_LS_BLANK;
                        end
                    endcase
                end
            end

            // blanking follows the qualified state, not the raw pin level
            assign lane_blank[g] = (lstate != sws_pkg::SWS_LS_STREAM);

            // all lanes share fall_tick so they never drift apart
            always_ff @(posedge clk) begin
                if (srst) begin
                    lp_a_out[g] <= 1'b1;
                    lp_b_out[g] <= 1'b1;
                    lp_c_out[g] <= 1'b1;
                end else if (fall_tick) begin
                    lp_a_out[g] <= lp_lvl[g][2];
                    lp_b_out[g] <= lp_lvl[g][1];
                    lp_c_out[g] <= lp_lvl[g][0];
                end
            end

            // an empty buffer streams zeros rather than repeating a stale word
            always_comb begin
                next_lane = 21'h000000;
                if (lane_blank[g] || !fq.rd_valid) begin
                    next_lane = 21'h000000;
                end else begin
                    next_lane = sws_lane_pick(rd_word[g], mode_data);
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    lane_bits[g*21 +: 21] <= 21'h000000;
                end else if (fall_tick) begin
                    lane_bits[g*21 +: 21] <= next_lane;
                end
            end
        end
    endgenerate
endmodule

//--- sws_stream_out_assertions.sv
module sws_stream_out_assertions (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        mode_data,
    input wire logic        in_valid,
    input wire logic        in_ready,
    input wire logic [3:0]  lp_a_pin,
    input wire logic        stream_clk,
    input wire logic [3:0]  lp_a_out,
    input wire logic [3:0]  lp_b_out,
    input wire logic [3:0]  lp_c_out,
    input wire logic [83:0] lane_bits
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    a_clk_toggle: assert property (!srst |=> stream_clk != $past(stream_clk))
        else $error("stream clock did not toggle");
    a_bits_aligned: assert property ($changed(lane_bits) |-> $fell(stream_clk))
        else $error("lane bits moved off the stream clock fall");
    a_lp_aligned: assert property ($changed({lp_a_out, lp_b_out, lp_c_out}) |->
        $fell(stream_clk))
        else $error("lp levels moved off the stream clock fall");
    a_reset_clear: assert property (disable iff (1'b0) srst |=>
        lane_bits == '0 && !stream_clk && in_ready)
        else $error("reset did not clear outputs");
    a_data_pad: assert property ($fell(stream_clk) && $past(mode_data) |->
        {lane_bits[83:80], lane_bits[62:59], lane_bits[41:38], lane_bits[20:17]} == 16'h0)
        else $error("data mode pad bits not zero");
    a_blank_zero: assert property ((lp_a_out[2] && lp_b_out[2] && lp_c_out[2])[*8] ##0
        $fell(stream_clk) |-> lane_bits[62:42] == 21'h0)
        else $error("stopped lane not blanked");
    a_lp_follow: assert property ($stable(lp_a_pin)[*8] ##0 $fell(stream_clk) |->
        lp_a_out == lp_a_pin)
        else $error("lp level output does not follow pin");
    a_ready_cause: assert property ($fell(in_ready) |-> $past(in_valid))
        else $error("buffer went full without a write");
    cover property ($fell(in_ready));
    cover property ($fell(stream_clk) && mode_data && lane_bits != '0);
    cover property (lp_a_out == 4'h0);
endmodule

//--- sws_rx_model.sv
module sws_rx_model (
    input wire logic        stream_clk,
    input wire logic [83:0] lane_bits
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [83:0] got[$];
    int          edges = 0;
    // zero words are blank or noise periods and are dropped
    always @(posedge stream_clk) begin
        edges++;
        if (lane_bits != '0)
            got.push_back(lane_bits);
    end
endmodule

//--- sws_stream_out_tb.sv
`include "sws_consts.svh"
module sws_stream_out_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk, srst, mode_data, in_valid, in_ready, stream_clk, full;
    logic [3:0]         lp_a_pin, lp_b_pin, lp_c_pin, lp_a_out, lp_b_out, lp_c_out;
    logic [83:0]        lane_bits;
    logic [31:0]        rng;
    sws_pkg::sws_word_t in_word;
    logic [83:0]        exp_q[$];
    int                 err_count, comparisons, e0;
    sws_stream_out sws_stream_out_i (.clk(clk), .srst(srst), .mode_data(mode_data),
        .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word), .lp_a_pin(lp_a_pin),
        .lp_b_pin(lp_b_pin), .lp_c_pin(lp_c_pin), .stream_clk(stream_clk),
        .lp_a_out(lp_a_out), .lp_b_out(lp_b_out), .lp_c_out(lp_c_out), .lane_bits(lane_bits));
    sws_rx_model sws_rx_model_i (.stream_clk(stream_clk), .lane_bits(lane_bits));
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [83:0] expect_bits(sws_pkg::sws_word_t w, logic md, logic [3:0] bl);
        logic [83:0] r;
        for (int g = 0; g < 4; g++)
            r[21*g +: 21] = bl[g] ? 21'h0 : md ? {4'h0, w[g].payload, w[g].num} : w[g].ws;
        return r;
    endfunction
    task automatic check(string what, logic [83:0] exp, logic [83:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // entered just after a rising edge; a word counts as taken when in_ready was high
    task automatic burst(int n, logic md, logic [3:0] bl);
        logic [159:0]       t;
        logic               acc;
        sws_pkg::sws_word_t w;
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 5; i++) begin
                rng = xs(rng);
                t[32*i +: 32] = rng;
            end
            w = t[151:0];
            in_word <= w;
            in_valid <= 1'b1;
            do begin
                @(negedge clk);
                acc = in_ready;
                full |= !acc;
                @(posedge clk);
            end while (!acc);
            if (expect_bits(w, md, bl) != '0)
                exp_q.push_back(expect_bits(w, md, bl));
        end
        in_valid <= 1'b0;
    endtask
    task automatic drain;
        repeat (80) @(posedge clk);
        check("word_count", exp_q.size(), sws_rx_model_i.got.size());
        foreach (exp_q[i])
            if (i < sws_rx_model_i.got.size())
                check("lane_bits", exp_q[i], sws_rx_model_i.got[i]);
        exp_q.delete();
        sws_rx_model_i.got.delete();
    endtask
    task automatic results;
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        {srst, mode_data, in_valid, full, in_word, rng} = {1'b1, 3'h0, 152'h0, 32'd90};
        {lp_a_pin, lp_b_pin, lp_c_pin} = 12'hfff;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check("reset_bits", 84'h0, lane_bits);
        burst(6, 1'b0, 4'hf);
        drain();
        lp_a_pin <= 4'h0;
        lp_b_pin <= 4'h0;
        lp_c_pin <= 4'h0;
        repeat (20) @(posedge clk);
        check("lp_out", 84'h0, {lp_a_out, lp_b_out, lp_c_out});
        burst(40, 1'b0, 4'h0);
        drain();
        check("buffer_full", 84'h1, full);
        mode_data <= 1'b1;
        repeat (8) @(posedge clk);
        burst(20, 1'b1, 4'h0);
        drain();
        {lp_a_pin[2], lp_b_pin[2], lp_c_pin[2]} <= 3'h7;
        repeat (20) @(posedge clk);
        burst(12, 1'b1, 4'h4);
        drain();
        e0 = sws_rx_model_i.edges;
        repeat (100) @(posedge clk);
        check("stream_edges", 100 / (2 * `SWS_HALF_CYC), sws_rx_model_i.edges - e0);
        results();
    end
endmodule
bind sws_stream_out sws_stream_out_assertions sws_stream_out_assertions_i (.clk(clk),
    .srst(srst), .mode_data(mode_data), .in_valid(in_valid), .in_ready(in_ready),
    .lp_a_pin(lp_a_pin), .stream_clk(stream_clk), .lp_a_out(lp_a_out),
    .lp_b_out(lp_b_out), .lp_c_out(lp_c_out), .lane_bits(lane_bits));
